// >>> design/vpio_pkg.sv
// Package: constants for the valve position input and output logic
package vpio_pkg;
   // APB register byte offsets
   localparam logic [7:0] VPIO_CTRL_OFF    = 8'h00;
   localparam logic [7:0] VPIO_HILIM_OFF   = 8'h04;
   localparam logic [7:0] VPIO_LOLIM_OFF   = 8'h08;
   localparam logic [7:0] VPIO_CMD_OFF     = 8'h0C;
   localparam logic [7:0] VPIO_POS_OFF     = 8'h10;
   localparam logic [7:0] VPIO_TARGET_OFF  = 8'h14;
   localparam logic [7:0] VPIO_FBK_OFF     = 8'h18;
   localparam logic [7:0] VPIO_STAT_OFF    = 8'h1C;
   localparam logic [7:0] VPIO_IRQ_OFF     = 8'h20;
   localparam logic [7:0] VPIO_MASK_OFF    = 8'h24;
   localparam logic [7:0] VPIO_TMO_OFF     = 8'h28;
   // Control register bits
   localparam int VPIO_CTRL_MANUAL = 0;
   localparam int VPIO_CTRL_MEMF   = 1;
   localparam int VPIO_CTRL_TAMPER = 2;
   // Status register bits (live conditions)
   localparam int VPIO_ST_COMM  = 0;
   localparam int VPIO_ST_ACT   = 1;
   localparam int VPIO_ST_STUCK = 2;
   localparam int VPIO_ST_HI    = 3;
   localparam int VPIO_ST_LO    = 4;
   localparam int VPIO_NEVT     = 5;
   // Positions in tenths of a degree, 0.0 .. 80.0
   localparam int VPIO_PW = 10;
   localparam logic [VPIO_PW-1:0] VPIO_HILIM_RST = 10'h320;
   localparam logic [VPIO_PW-1:0] VPIO_LOLIM_RST = 10'h000;
   localparam logic [VPIO_PW-1:0] VPIO_FULL_ANGLE = 10'h320;
   // Position index limits
   localparam logic [3:0] VPIO_IDX_MIN = 4'h0;
   localparam logic [3:0] VPIO_IDX_MAX = 4'h9;
   // Loop current codes in microamps
   localparam int VPIO_CW = 15;
   localparam logic [VPIO_CW-1:0] VPIO_I_MIN  = 15'h0FA0;
   localparam logic [VPIO_CW-1:0] VPIO_I_MAX  = 15'h4E20;
   localparam logic [VPIO_CW-1:0] VPIO_I_SPAN = 15'h3E80;
   // Reply timeout
   localparam int VPIO_CLK_MHZ = 250;
   localparam int VPIO_TMO_US  = 100;
   localparam int VPIO_TMO_CYC = VPIO_TMO_US * VPIO_CLK_MHZ;
   // Unmapped read value
   localparam logic [31:0] VPIO_RD_ZERO = 32'h0000_0000;
endpackage

// >>> design/vpio_cmd_map.sv
// Position command current to characterized position index, with forcing inputs
`timescale 1ns/1ps
module vpio_cmd_map
   import vpio_pkg::*;
#(
   parameter bit VERSION_ONE = 1'b0
) (
   // Inputs
   input  wire logic [VPIO_CW-1:0] cmd_current,
   input  wire logic               force_max,
   input  wire logic               force_min,
   // Result
   output logic [3:0]              target_idx
);
   logic [VPIO_CW-1:0] clamped;
   logic [31:0]        scaled;
   always_comb begin
      if (cmd_current < VPIO_I_MIN)
         clamped = VPIO_I_MIN;
      else if (cmd_current > VPIO_I_MAX)
         clamped = VPIO_I_MAX;
      else
         clamped = cmd_current;
      // Round to nearest index over the 16 mA span
      scaled = (32'(clamped - VPIO_I_MIN) * 32'(VPIO_IDX_MAX) + 32'(VPIO_I_SPAN >> 1))
               / 32'(VPIO_I_SPAN);
      if (!VERSION_ONE && force_min)
         target_idx = VPIO_IDX_MIN;
      else if (!VERSION_ONE && force_max)
         target_idx = VPIO_IDX_MAX;
      else
         target_idx = scaled[3:0];
   end
endmodule // vpio_cmd_map

// >>> design/vpio_fbk.sv
// Valve angle to feedback loop current code
`timescale 1ns/1ps
module vpio_fbk
   import vpio_pkg::*;
(
   // Angle in tenths of a degree
   input  wire logic [VPIO_PW-1:0] angle,
   // Feedback current in microamps
   output logic [VPIO_CW-1:0]      fbk_current
);
   logic [31:0] prod;
   logic [VPIO_PW-1:0] a;
   always_comb begin
      a = (angle > VPIO_FULL_ANGLE) ? VPIO_FULL_ANGLE : angle;
      // 4 mA + 16 mA * angle / 80 degrees
      prod = 32'(VPIO_I_MIN) + (32'(a) * 32'(VPIO_I_SPAN)) / 32'(VPIO_FULL_ANGLE);
      fbk_current = prod[VPIO_CW-1:0];
   end
endmodule // vpio_fbk

// >>> design/vpio_top.sv
// Valve position input and output logic with APB registers
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module vpio_top
   import vpio_pkg::*;
#(
   parameter bit          VERSION_ONE = 1'b0,
   parameter int unsigned TMO_CYCLES  = VPIO_TMO_CYC
) (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Field pins
   input  wire logic               force_max_relay_in,
   input  wire logic               force_min_relay_in,
   input  wire logic [3:0]         spare_relay_in,
   input  wire logic [VPIO_CW-1:0] position_command_current,
   input  wire logic [VPIO_CW-1:0] spare_current_input,
   // Actuator side, from network decoder logic on pclk
   input  wire logic               reply_valid,
   input  wire logic [VPIO_PW-1:0] reply_angle,
   input  wire logic               reply_act_alarm,
   input  wire logic               reply_stuck,
   // Results
   output logic [3:0]              target_index,
   output logic [VPIO_CW-1:0]      feedback_current,
   output logic                    alarm_driver,
   output logic                    control_enable_driver,
   output logic                    high_limit_driver,
   output logic                    low_limit_driver,
   output logic                    manual_control_driver,
   output logic                    irq
);
   typedef struct packed {
      logic [1:0]          fmax_sync;
      logic [1:0]          fmin_sync;
      logic [2:0]          ctrl;
      logic [VPIO_PW-1:0]  hilim;
      logic [VPIO_PW-1:0]  lolim;
      logic [VPIO_CW-1:0]  cmd_in;
      logic [VPIO_PW-1:0]  angle;
      logic                act_alarm;
      logic                stuck;
      logic                comm_fault;
      logic [31:0]         tmo_cnt;
      logic [31:0]         tmo_limit;
      logic [VPIO_NEVT-1:0] live_q;
      logic [VPIO_NEVT-1:0] irq_stat;
      logic [VPIO_NEVT-1:0] irq_mask;
      logic [3:0]          target;
      logic [VPIO_CW-1:0]  fbk;
      logic                alarm;
      logic                cen;
      logic                hi;
      logic                lo;
      logic                man;
      logic                irq;
      logic [31:0]         rdata;
      logic                ready;
   } vpio_state_t;

   vpio_state_t st_reg, st_next;
   logic [3:0]          map_idx;
   logic [VPIO_CW-1:0]  fbk_cur;
   logic [VPIO_NEVT-1:0] live;
   logic                memf, tamper, comm_now;
   logic                wr, rd;

   // Spare inputs are deliberately left unread
   vpio_cmd_map #(.VERSION_ONE(VERSION_ONE)) u_map (
      .cmd_current (st_reg.cmd_in),
      .force_max   (st_reg.fmax_sync[1]),
      .force_min   (st_reg.fmin_sync[1]),
      .target_idx  (map_idx)
   );

   vpio_fbk u_fbk (
      .angle       (st_reg.angle),
      .fbk_current (fbk_cur)
   );

   always_comb begin
      st_next = st_reg;
      // A write lands only at the edge where the master sees pready high
      wr = psel && penable && pwrite && st_reg.ready;
      rd = psel && !penable;
      memf   = st_reg.ctrl[VPIO_CTRL_MEMF];
      tamper = st_reg.ctrl[VPIO_CTRL_TAMPER];
      // Pins are asynchronous to pclk
      st_next.fmax_sync = {st_reg.fmax_sync[0], force_max_relay_in};
      st_next.fmin_sync = {st_reg.fmin_sync[0], force_min_relay_in};
      st_next.cmd_in    = position_command_current;
      // Reply watchdog
      if (reply_valid) begin
         st_next.angle      = reply_angle;
         st_next.act_alarm  = reply_act_alarm;
         st_next.stuck      = reply_stuck;
         st_next.tmo_cnt    = '0;
         st_next.comm_fault = 1'b0;
      end else if (st_reg.tmo_cnt >= st_reg.tmo_limit - 32'h0000_0001) begin
         st_next.comm_fault = 1'b1;
      end else begin
         st_next.tmo_cnt = st_reg.tmo_cnt + 32'h0000_0001;
      end
      comm_now = st_reg.comm_fault;
      // Drivers recompute every cycle, nothing latches
      st_next.alarm = comm_now | memf | st_reg.act_alarm | tamper;
      st_next.cen   = comm_now | memf | st_reg.stuck;
      st_next.hi    = st_reg.angle >= st_reg.hilim;
      st_next.lo    = st_reg.angle <= st_reg.lolim;
      st_next.man   = st_reg.ctrl[VPIO_CTRL_MANUAL];
      st_next.target = map_idx;
      st_next.fbk    = fbk_cur;
      // Events are rising edges of the live conditions
      live = '0;
      live[VPIO_ST_COMM]  = comm_now;
      live[VPIO_ST_ACT]   = st_reg.act_alarm;
      live[VPIO_ST_STUCK] = st_reg.stuck;
      live[VPIO_ST_HI]    = st_reg.hi;
      live[VPIO_ST_LO]    = st_reg.lo;
      st_next.live_q = live;
      // APB: setup cycle prepares data, access completes with no wait state
      st_next.ready = psel && !penable;
      if (wr) begin
         unique case (paddr)
            VPIO_CTRL_OFF:  st_next.ctrl      = pwdata[2:0];
            VPIO_HILIM_OFF: st_next.hilim     = pwdata[VPIO_PW-1:0];
            VPIO_LOLIM_OFF: st_next.lolim     = pwdata[VPIO_PW-1:0];
            VPIO_MASK_OFF:  st_next.irq_mask  = pwdata[VPIO_NEVT-1:0];
            VPIO_TMO_OFF:   st_next.tmo_limit = pwdata;
            VPIO_IRQ_OFF:   st_next.irq_stat  = st_reg.irq_stat & ~pwdata[VPIO_NEVT-1:0];
            default: ;
         endcase
      end
      // Set wins over a simultaneous clear
      st_next.irq_stat = st_next.irq_stat | (live & ~st_reg.live_q);
      st_next.irq = |(st_reg.irq_stat & st_reg.irq_mask);
      if (rd) begin
         unique case (paddr)
            VPIO_CTRL_OFF:   st_next.rdata = 32'(st_reg.ctrl);
            VPIO_HILIM_OFF:  st_next.rdata = 32'(st_reg.hilim);
            VPIO_LOLIM_OFF:  st_next.rdata = 32'(st_reg.lolim);
            VPIO_CMD_OFF:    st_next.rdata = 32'(st_reg.cmd_in);
            VPIO_POS_OFF:    st_next.rdata = 32'(st_reg.angle);
            VPIO_TARGET_OFF: st_next.rdata = 32'(st_reg.target);
            VPIO_FBK_OFF:    st_next.rdata = 32'(st_reg.fbk);
            VPIO_STAT_OFF:   st_next.rdata = 32'(live);
            VPIO_IRQ_OFF:    st_next.rdata = 32'(st_reg.irq_stat);
            VPIO_MASK_OFF:   st_next.rdata = 32'(st_reg.irq_mask);
            VPIO_TMO_OFF:    st_next.rdata = st_reg.tmo_limit;
            default:         st_next.rdata = VPIO_RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg           <= '0;
         st_reg.hilim     <= VPIO_HILIM_RST;
         st_reg.lolim     <= VPIO_LOLIM_RST;
         st_reg.tmo_limit <= 32'(TMO_CYCLES);
         st_reg.lo        <= 1'b1;
         // Edge detector starts at the driver's reset level, so no false event
         st_reg.live_q[VPIO_ST_LO] <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata                = st_reg.rdata;
   assign pready                = st_reg.ready;
   assign pslverr               = 1'b0;
   assign target_index          = st_reg.target;
   assign feedback_current      = st_reg.fbk;
   assign alarm_driver          = st_reg.alarm;
   assign control_enable_driver = st_reg.cen;
   assign high_limit_driver     = st_reg.hi;
   assign low_limit_driver      = st_reg.lo;
   assign manual_control_driver = st_reg.man;
   assign irq                   = st_reg.irq;

   // Assertions
   a_force_min_wins: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.fmin_sync[1] && !VERSION_ONE |=> target_index == VPIO_IDX_MIN)
      else $error("forced minimum not applied");
   a_force_max_idx: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.fmax_sync[1] && !st_reg.fmin_sync[1] && !VERSION_ONE
      |=> target_index == VPIO_IDX_MAX)
      else $error("forced maximum not applied");
   a_alarm_follow: assert property (@(posedge pclk) disable iff (!presetn)
      alarm_driver == $past(comm_now | memf | st_reg.act_alarm | tamper))
      else $error("alarm driver wrong");
   a_cen_follow: assert property (@(posedge pclk) disable iff (!presetn)
      control_enable_driver == $past(comm_now | memf | st_reg.stuck))
      else $error("control enable driver wrong");
   a_high_limit: assert property (@(posedge pclk) disable iff (!presetn)
      high_limit_driver == $past(st_reg.angle >= st_reg.hilim))
      else $error("high limit driver wrong");
   a_low_limit: assert property (@(posedge pclk) disable iff (!presetn)
      low_limit_driver == $past(st_reg.angle <= st_reg.lolim))
      else $error("low limit driver wrong");
   a_manual_drv: assert property (@(posedge pclk) disable iff (!presetn)
      manual_control_driver == $past(st_reg.ctrl[VPIO_CTRL_MANUAL]))
      else $error("manual driver wrong");
   a_reply_clears: assert property (@(posedge pclk) disable iff (!presetn)
      reply_valid |=> !st_reg.comm_fault ##1
      (!alarm_driver || $past(memf || tamper || st_reg.act_alarm)))
      else $error("reply did not clear comm fault");
endmodule // vpio_top

// >>> verif/vpio_act_model.sv
// Valve actuator model: periodic replies on the network decoder side
`timescale 1ns/1ps
module vpio_act_model
   import vpio_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Behaviour set by the bench
   input  wire logic               silent,
   input  wire logic [7:0]         gap,
   input  wire logic [VPIO_PW-1:0] angle,
   input  wire logic               act_alarm,
   input  wire logic               stuck,
   // Replies
   output logic                    reply_valid,
   output logic [VPIO_PW-1:0]      reply_angle,
   output logic                    reply_act_alarm,
   output logic                    reply_stuck
);
   logic [7:0] cnt;
   logic       ok;
   assign ok = !silent && (cnt >= gap);
   // Fields are inverted outside a reply so stale data is never mistaken for a reply
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt             <= 8'h00;
         reply_valid     <= 1'b0;
         reply_angle     <= '0;
         reply_act_alarm <= 1'b0;
         reply_stuck     <= 1'b0;
      end else begin
         cnt             <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
         reply_valid     <= ok;
         reply_angle     <= ok ? angle : ~angle;
         reply_act_alarm <= ok ? act_alarm : ~act_alarm;
         reply_stuck     <= ok ? stuck : ~stuck;
      end
   end
endmodule // vpio_act_model

// >>> verif/tb.sv
// Self-checking bench for the valve position input and output logic
`timescale 1ns/1ps
module tb;
   import vpio_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0, gap = 8'h05;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, fmax = 0, fmin = 0, silent = 0, act = 0, stk = 0;
   logic [3:0] spr = 0, tgt, tgt1;
   logic [VPIO_CW-1:0] cur = 15'h0FA0, scur = 0, fbk;
   logic [VPIO_PW-1:0] ang = 0, r_ang;
   logic rv, r_act, r_stk, al, ce, hi, lo, man, irq, slverr;
   int miscompares = 0, checked = 0, c, h, l, a;
   always #2 pclk = ~pclk;
   vpio_act_model act_m (.pclk(pclk), .presetn(presetn), .silent(silent), .gap(gap),
      .angle(ang), .act_alarm(act), .stuck(stk), .reply_valid(rv), .reply_angle(r_ang),
      .reply_act_alarm(r_act), .reply_stuck(r_stk));
   vpio_top #(.VERSION_ONE(1'b0), .TMO_CYCLES(50)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(slverr), .force_max_relay_in(fmax),
      .force_min_relay_in(fmin), .spare_relay_in(spr), .position_command_current(cur),
      .spare_current_input(scur), .reply_valid(rv), .reply_angle(r_ang),
      .reply_act_alarm(r_act), .reply_stuck(r_stk), .target_index(tgt),
      .feedback_current(fbk), .alarm_driver(al), .control_enable_driver(ce),
      .high_limit_driver(hi), .low_limit_driver(lo), .manual_control_driver(man), .irq(irq));
   vpio_top #(.VERSION_ONE(1'b1), .TMO_CYCLES(50)) uut1 (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .force_max_relay_in(fmax),
      .force_min_relay_in(fmin), .spare_relay_in(spr), .position_command_current(cur),
      .spare_current_input(scur), .reply_valid(rv), .reply_angle(r_ang),
      .reply_act_alarm(r_act), .reply_stuck(r_stk), .target_index(tgt1),
      .feedback_current(), .alarm_driver(), .control_enable_driver(),
      .high_limit_driver(), .low_limit_driver(), .manual_control_driver(), .irq());
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n == 50) miscompares++;
      chk("pslverr", 0, slverr);
      q = prdata;
      psel <= 0; penable <= 0;
   endtask
   // Waits for a fresh reply so captured fields have reached the outputs
   task automatic settle();
      int n;
      n = 0;
      // A reply launched at the edge that changed the stimulus still carries old fields
      repeat (2) @(posedge pclk);
      while (rv !== 1'b1 && n < 300) begin
         n++;
         @(posedge pclk);
      end
      if (n == 300) miscompares++;
      repeat (5) @(posedge pclk);
   endtask
   // Expected index: nearest of 0..9 over 4..20 mA, forcing unless version one
   function automatic int exp_idx(int cc, bit mx, bit mn, bit v1);
      if (!v1 && mn) return 0;
      if (!v1 && mx) return 9;
      return ((cc - 4000) * 9 + 8000) / 16000;
   endfunction
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #80000;
      miscompares++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h0a5cf019));
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk("lo_rst", 1, lo);
      chk("hi_rst", 0, hi);
      chk("al_rst", 0, al);
      apb(0, VPIO_HILIM_OFF, 0);
      chk("hilim", 32'h320, q);
      apb(0, VPIO_LOLIM_OFF, 0);
      chk("lolim", 0, q);
      apb(0, 8'h3C, 0);
      chk("unmapped", VPIO_RD_ZERO, q);
      for (int i = 0; i < 40; i++) begin
         c = (i == 0) ? 4000 : (i == 1) ? 20000 : 4000 + $urandom_range(16000);
         fmax <= (i > 3) && $urandom_range(1); fmin <= (i > 3) && ($urandom_range(3) == 0);
         spr <= $urandom; scur <= $urandom; cur <= c;
         repeat (7) @(posedge pclk);
         chk("tgt", exp_idx(c, fmax, fmin, 0), tgt);
         chk("tgt_v1", exp_idx(c, fmax, fmin, 1), tgt1);
      end
      for (int i = 0; i < 8; i++) begin
         h = $urandom_range(800); l = $urandom_range(800);
         a = (i == 0) ? h : (i == 1) ? l : (i == 2) ? 0 : (i == 3) ? 800 : $urandom_range(800);
         gap <= (i < 4) ? 8'h01 : 8'h28;
         apb(1, VPIO_HILIM_OFF, h);
         apb(1, VPIO_LOLIM_OFF, l);
         ang <= a;
         settle();
         chk("fbk", 4000 + 20 * a, fbk);
         chk("hi", a >= h, hi);
         chk("lo", a <= l, lo);
         apb(0, VPIO_POS_OFF, 0);
         chk("pos_reg", a, q);
         apb(0, VPIO_FBK_OFF, 0);
         chk("fbk_reg", 4000 + 20 * a, q);
      end
      for (int i = 0; i < 32; i++) begin
         apb(1, VPIO_CTRL_OFF, i & 7);
         act <= i[3]; stk <= i[4];
         settle();
         chk("alarm", i[1] | i[2] | i[3], al);
         chk("ctl_en", i[1] | i[4], ce);
         chk("manual", i[0], man);
      end
      apb(1, VPIO_CTRL_OFF, 0);
      act <= 0; stk <= 0;
      apb(1, VPIO_IRQ_OFF, 32'h1F);
      silent <= 1;
      repeat (80) @(posedge pclk);
      chk("irq_masked", 0, irq);
      chk("alarm_comm", 1, al);
      chk("ctl_en_comm", 1, ce);
      apb(0, VPIO_STAT_OFF, 0);
      chk("stat_comm", 1, q[VPIO_ST_COMM]);
      apb(1, VPIO_MASK_OFF, 1);
      repeat (3) @(posedge pclk);
      chk("irq_on", 1, irq);
      silent <= 0;
      settle();
      chk("alarm_clr", 0, al);
      chk("irq_sticky", 1, irq);
      apb(1, VPIO_IRQ_OFF, 1);
      repeat (3) @(posedge pclk);
      chk("irq_clr", 0, irq);
      end_of_test();
   end
endmodule // tb
